/* rtl/phy_irq_status_regs.sv */
/*
 * Status and interrupt registers of the transceiver behind a serial
 * management slave: advanced read window, polarity status, sticky
 * interrupt flags with enables, and the negotiation result.
 * Assumes MDC is well below the core clock (at most about 2.5 MHz)
 * and that advanced register data follows the index combinationally.
 */
// What this block does
// [R1] The read data port returns the advanced register last fetched, is read-only and resets to 0.
// [R2] The manager fetches by writing the address port with the read bit and index, then reads data.
// [R3] Indications bit 4 shows 10 Mbps receive polarity, 1 meaning reversed.
// [R4] Flags 10 and 9 latch transmit buffer overflow and underflow until written clear.
// [R5] Flag 8 latches an idle error counter overflow until written clear.
// [R6] Flag 7 latches a rising edge of the energy present status.
// [R7] Flag 6 latches completion of auto-negotiation until written clear.
// [R8] Flag 5 latches a detected remote fault until written clear.
// [R9] Flag 4 latches the link going down until written clear.
// [R10] Flag 3 latches a partner acknowledge until written clear.
// [R11] Flag 2 latches a parallel detection fault or a role fault until written clear.
// [R12] Flag 1 latches a received page; bits 0 and 15 to 11 read as zero.
// [R13] Mask bits 10 to 1 enable their sources when 1 and reset to 0.
// [R14] The interrupt output is registered: it goes high one clock after any enabled flag is set and falls one clock after none is.
// [R15] Special status bit 12 mirrors negotiation done and reading it clears nothing.
// [R16] Special status bits 4 to 2 give the resolved speed and duplex code.
`timescale 1ns/10ps
`default_nettype none

module phy_irq_status_regs
	import phy_irq_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	input  wire logic [4:0]  phy_addr_i,
	input  wire phy_status_t status_i,
	output logic [6:0]       adv_index_o,
	input  wire logic [15:0] adv_data_i,
	output logic             irq_o
);

	typedef struct packed {
		smi_state_t  fsm;
		logic [5:0]  cnt;
		logic [15:0] shift;
		logic        is_read;
		logic [4:0]  reg_addr;
		logic        mdc_prev;
		logic        mdio_out;
		logic        mdio_oe;
		logic [7:0]  adv_ctl;
		logic [6:0]  adv_index;
		logic        adv_pending;
		logic [15:0] adv_data;
		flag_vec_t   mask;
		logic        prev_energy;
		logic        prev_link;
		logic        prev_an;
		logic        irq;
	} regs_state_t;

	regs_state_t state;
	regs_state_t next_state;

	logic [6:0]  sync_q;
	logic        mdc_s;
	logic        mdio_s;
	logic [4:0]  phy_addr_s;
	logic        mdc_rise;
	logic [15:0] write_data;
	logic        write_commit;
	logic [9:0]  addr_bits;
	logic        addr_done;
	logic        addr_match;
	logic        load_read;
	flag_vec_t   flags;
	flag_vec_t   set_vec;
	flag_vec_t   clear_vec;
	flag_vec_t   write_field;
	logic [15:0] read_word;

	// Pins come from the manager's domain
	bit_sync #(
		.WIDTH(7)
	) u_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.d_i    ({phy_addr_i, mdio_i, mdc_i}),
		.q_o    (sync_q)
	);

	assign mdc_s      = sync_q[0];
	assign mdio_s     = sync_q[1];
	assign phy_addr_s = sync_q[6:2];

	// Frame decode helpers, all off the synchronised copies
	assign mdc_rise     = mdc_s & ~state.mdc_prev;
	assign write_data   = {state.shift[14:0], mdio_s};
	assign write_commit = (state.fsm == st_write) && mdc_rise && (state.cnt == DATA_LAST);
	assign addr_bits    = {state.shift[8:0], mdio_s};
	assign addr_done    = (state.fsm == st_addr) && mdc_rise && (state.cnt == ADDR_LAST);
	assign addr_match   = (addr_bits[9:5] == phy_addr_s);
	assign load_read    = addr_done && addr_match && state.is_read;
	assign write_field  = write_data[FLAG_HI:FLAG_LO];

	// Event sources into the sticky flags
	always_comb begin
		set_vec                     = '0;
		set_vec[FLAG_TX_OVERFLOW]   = status_i.tx_overflow; // see [R4]
		set_vec[FLAG_TX_UNDERFLOW]  = status_i.tx_underflow; // see [R4]
		set_vec[FLAG_IDLE_ERR]      = status_i.idle_err_overflow; // see [R5]
		set_vec[FLAG_ENERGY]        = status_i.energy_present & ~state.prev_energy; // see [R6]
		set_vec[FLAG_AN_COMPLETE]   = status_i.autoneg_done & ~state.prev_an; // see [R7]
		set_vec[FLAG_REMOTE_FAULT]  = status_i.remote_fault; // see [R8]
		set_vec[FLAG_LINK_DOWN]     = ~status_i.link_up & state.prev_link; // see [R9]
		set_vec[FLAG_PARTNER_ACK]   = status_i.partner_ack; // see [R10]
		set_vec[FLAG_DETECT_FAULT]  = status_i.detect_fault | status_i.role_fault; // see [R11]
		set_vec[FLAG_PAGE_RECEIVED] = status_i.page_received; // see [R12]
	end

	// Write of ones to the flag register clears those flags
	always_comb begin
		clear_vec = '0;
		if (write_commit && (state.reg_addr == REG_FLAGS)) begin
			clear_vec = write_field; // see [R4]
		end
	end

	flag_latch u_flags (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.set_i  (set_vec),
		.clear_i(clear_vec),
		.flags_o(flags)
	);

	// Word returned by a read, chosen as the register address completes
	always_comb begin
		read_word = 16'h0000;
		case (addr_bits[4:0])
			REG_ADV_ADDR: begin
				// Read bit is self-clearing, so it always reads 0
				read_word[ADV_CTL_MSB:ADV_CTL_LSB] = state.adv_ctl;
				read_word[ADV_INDEX_W-1:0]         = state.adv_index;
			end
			REG_ADV_DATA: begin
				read_word = state.adv_data; // see [R1]
			end
			REG_INDICATIONS: begin
				read_word[POLARITY_BIT] = status_i.ten_meg_polarity_reversed; // see [R3]
			end
			REG_FLAGS: begin
				read_word[FLAG_HI:FLAG_LO] = flags; // see [R12]
			end
			REG_MASK: begin
				read_word[FLAG_HI:FLAG_LO] = state.mask; // see [R13]
			end
			REG_SPECIAL: begin
				// Plain level copy, so this read clears nothing
				read_word[AN_DONE_BIT]         = status_i.autoneg_done; // see [R15]
				read_word[SPEED_MSB:SPEED_LSB] = status_i.resolved_speed_duplex; // see [R16]
			end
			default: begin
				read_word = 16'h0000;
			end
		endcase
	end

	// Frame walker; it moves only on a synchronised MDC rise
	always_comb begin
		next_state             = state;
		next_state.mdc_prev    = mdc_s;
		next_state.prev_energy = status_i.energy_present;
		next_state.prev_link   = status_i.link_up;
		next_state.prev_an     = status_i.autoneg_done;
		next_state.adv_pending = 1'b0;
		next_state.irq         = |(flags & state.mask); // see [R14]
		// Fetch lands one cycle after the index, once the core has settled
		if (state.adv_pending) begin
			next_state.adv_data = adv_data_i; // see [R1]
		end
		if (mdc_rise) begin
			case (state.fsm)
				st_preamble: begin
					if (mdio_s) begin
						// Saturate so a long idle line still counts as preamble
						if (state.cnt != PREAMBLE_BITS) begin
							next_state.cnt = 6'(state.cnt + 6'h01);
						end
					end else if (state.cnt == PREAMBLE_BITS) begin
						next_state.fsm = st_start;
						next_state.cnt = 6'h00;
					end else begin
						next_state.cnt = 6'h00;
					end
				end
				st_start: begin
					next_state.cnt = 6'h00;
					if (mdio_s) begin
						next_state.fsm = st_op;
					end else begin
						next_state.fsm = st_preamble;
					end
				end
				st_op: begin
					next_state.shift = {state.shift[14:0], mdio_s};
					if (state.cnt == 6'h00) begin
						next_state.cnt = 6'h01;
					end else if ({state.shift[0], mdio_s} == OP_READ) begin
						next_state.is_read = 1'b1;
						next_state.fsm     = st_addr;
						next_state.cnt     = 6'h00;
					end else if ({state.shift[0], mdio_s} == OP_WRITE) begin
						next_state.is_read = 1'b0;
						next_state.fsm     = st_addr;
						next_state.cnt     = 6'h00;
					end else begin
						// Unknown opcode: drop the frame and wait for preamble
						next_state.fsm = st_preamble;
						next_state.cnt = 6'h00;
					end
				end
				st_addr: begin
					next_state.shift = {state.shift[14:0], mdio_s};
					next_state.cnt   = 6'(state.cnt + 6'h01);
					if (addr_done) begin
						next_state.cnt = 6'h00;
						if (addr_match) begin
							next_state.fsm      = st_ta;
							next_state.reg_addr = addr_bits[4:0];
						end else begin
							// Frame for another station: stay off the line
							next_state.fsm = st_preamble;
						end
						if (load_read) begin
							next_state.shift = read_word; // see [R15]
						end
					end
				end
				st_ta: begin
					if (state.cnt == 6'h00) begin
						next_state.cnt = 6'h01;
						if (state.is_read) begin
							next_state.mdio_out = 1'b0;
							next_state.mdio_oe  = 1'b1;
						end
					end else if (state.is_read) begin
						next_state.cnt      = 6'h00;
						next_state.fsm      = st_read;
						next_state.mdio_out = state.shift[15];
						next_state.shift    = {state.shift[14:0], 1'b0};
					end else begin
						next_state.cnt = 6'h00;
						next_state.fsm = st_write;
					end
				end
				st_read: begin
					if (state.cnt == DATA_LAST) begin
						next_state.fsm     = st_preamble;
						next_state.cnt     = 6'h00;
						next_state.mdio_oe = 1'b0;
					end else begin
						next_state.cnt      = 6'(state.cnt + 6'h01);
						next_state.mdio_out = state.shift[15];
						next_state.shift    = {state.shift[14:0], 1'b0};
					end
				end
				st_write: begin
					next_state.shift = write_data;
					next_state.cnt   = 6'(state.cnt + 6'h01);
					if (write_commit) begin
						next_state.fsm = st_preamble;
						next_state.cnt = 6'h00;
					end
				end
				default: begin
					next_state.fsm     = st_preamble;
					next_state.cnt     = 6'h00;
					next_state.mdio_oe = 1'b0;
				end
			endcase
		end
		// Register updates at the last data bit of a write frame
		if (write_commit) begin
			case (state.reg_addr)
				REG_ADV_ADDR: begin
					next_state.adv_ctl = write_data[ADV_CTL_MSB:ADV_CTL_LSB];
					// Index only moves with the read bit, keeping the last fetch
					if (write_data[ADV_READ_BIT]) begin
						next_state.adv_index   = write_data[ADV_INDEX_W-1:0]; // see [R1]
						next_state.adv_pending = 1'b1;
					end
				end
				REG_MASK: begin
					next_state.mask = write_field; // see [R13]
				end
				default: begin
					next_state.adv_ctl = state.adv_ctl;
				end
			endcase
		end
	end

	// Reset loads constants only
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state.fsm         <= st_preamble;
			state.cnt         <= 6'h00;
			state.shift       <= 16'h0000;
			state.is_read     <= 1'b0;
			state.reg_addr    <= 5'h00;
			state.mdc_prev    <= 1'b0;
			state.mdio_out    <= 1'b1;
			state.mdio_oe     <= 1'b0;
			state.adv_ctl     <= ADV_CTL_RESET;
			state.adv_index   <= ADV_INDEX_RESET;
			state.adv_pending <= 1'b0;
			state.adv_data    <= ADV_DATA_RESET; // see [R1]
			state.mask        <= MASK_RESET; // see [R13]
			state.prev_energy <= 1'b0;
			state.prev_link   <= 1'b0;
			state.prev_an     <= 1'b0;
			state.irq         <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Pin and port outputs straight from flops
	assign mdio_o      = state.mdio_out;
	assign mdio_oe_o   = state.mdio_oe;
	assign adv_index_o = state.adv_index;
	assign irq_o       = state.irq;

	// Register side checks
	a_irq_on_enabled: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R14]
		(|(flags & state.mask)) |=> irq_o)
		else $error("interrupt low with an enabled flag set");
	a_irq_off_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R14]
		(!(|(flags & state.mask))) |=> !irq_o)
		else $error("interrupt high with no enabled flag");
	a_fetch_latch: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R1]
		state.adv_pending |=> (state.adv_data == $past(adv_data_i)))
		else $error("advanced data not latched after a fetch");
	a_data_port_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R1]
		(!state.adv_pending) |=> $stable(state.adv_data))
		else $error("advanced data changed without a fetch");
	a_mask_write: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R13]
		(write_commit && (state.reg_addr == REG_MASK)) |=> (state.mask == $past(write_field)))
		else $error("mask write did not land");
	a_flag_read_word: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R12]
		(load_read && (addr_bits[4:0] == REG_FLAGS)) |=> (state.shift == {5'h00, $past(flags), 1'b0}))
		else $error("flag read word wrong or reserved bits set");
	a_line_released: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R1]
		((state.fsm != st_ta) && (state.fsm != st_read)) |-> !mdio_oe_o)
		else $error("data line driven outside a read");
	// Main scenarios
	c_read_frame: cover property (@(posedge clock_i) disable iff (!rst_n_i) load_read);
	c_flag_clear: cover property (@(posedge clock_i) disable iff (!rst_n_i) (|clear_vec));
	c_irq_rise: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(irq_o));

endmodule

`default_nettype wire

/* rtl/phy_irq_pkg.sv */
/*
 * Shared constants and types for the transceiver status and interrupt
 * register block: management register indices, field positions, reset
 * values, frame codes and the status carrier struct.
 * Assumes a 16-bit register file reached by serial management frames.
 */
package phy_irq_pkg;

	// Register indices on the management interface
	localparam logic [4:0] REG_ADV_ADDR    = 5'h14;
	localparam logic [4:0] REG_ADV_DATA    = 5'h15;
	localparam logic [4:0] REG_INDICATIONS = 5'h1b;
	localparam logic [4:0] REG_FLAGS       = 5'h1d;
	localparam logic [4:0] REG_MASK        = 5'h1e;
	localparam logic [4:0] REG_SPECIAL     = 5'h1f;

	// Advanced address port fields
	localparam int ADV_READ_BIT = 15;
	localparam int ADV_CTL_MSB  = 14;
	localparam int ADV_CTL_LSB  = 7;
	localparam int ADV_INDEX_W  = 7;

	// Status field positions
	localparam int POLARITY_BIT = 4;
	localparam int AN_DONE_BIT  = 12;
	localparam int SPEED_MSB    = 4;
	localparam int SPEED_LSB    = 2;

	// Interrupt flag positions
	localparam int FLAG_LO            = 1;
	localparam int FLAG_HI            = 10;
	localparam int FLAG_TX_OVERFLOW   = 10;
	localparam int FLAG_TX_UNDERFLOW  = 9;
	localparam int FLAG_IDLE_ERR      = 8;
	localparam int FLAG_ENERGY        = 7;
	localparam int FLAG_AN_COMPLETE   = 6;
	localparam int FLAG_REMOTE_FAULT  = 5;
	localparam int FLAG_LINK_DOWN     = 4;
	localparam int FLAG_PARTNER_ACK   = 3;
	localparam int FLAG_DETECT_FAULT  = 2;
	localparam int FLAG_PAGE_RECEIVED = 1;

	typedef logic [FLAG_HI:FLAG_LO] flag_vec_t;

	// Values after reset
	localparam logic [15:0] ADV_DATA_RESET  = 16'h0000;
	localparam logic [7:0]  ADV_CTL_RESET   = 8'h00;
	localparam logic [6:0]  ADV_INDEX_RESET = 7'h00;
	localparam flag_vec_t   FLAGS_RESET     = 10'h000;
	localparam flag_vec_t   MASK_RESET      = 10'h000;

	// Management frame
	localparam logic [5:0] PREAMBLE_BITS = 6'h20;
	localparam logic [1:0] OP_READ       = 2'b10;
	localparam logic [1:0] OP_WRITE      = 2'b01;
	localparam logic [5:0] ADDR_LAST     = 6'h09;
	localparam logic [5:0] DATA_LAST     = 6'h0f;

	// Resolved speed and duplex codes
	localparam logic [2:0] SPEED_10_HALF  = 3'b001;
	localparam logic [2:0] SPEED_10_FULL  = 3'b101;
	localparam logic [2:0] SPEED_100_HALF = 3'b010;
	localparam logic [2:0] SPEED_100_FULL = 3'b110;

	typedef enum logic [2:0] {
		st_preamble,
		st_start,
		st_op,
		st_addr,
		st_ta,
		st_read,
		st_write
	} smi_state_t;

	// Event pulses and status levels from the transceiver core
	typedef struct packed {
		logic       tx_overflow;
		logic       tx_underflow;
		logic       idle_err_overflow;
		logic       remote_fault;
		logic       partner_ack;
		logic       detect_fault;
		logic       role_fault;
		logic       page_received;
		logic       energy_present;
		logic       link_up;
		logic       autoneg_done;
		logic       ten_meg_polarity_reversed;
		logic [2:0] resolved_speed_duplex;
	} phy_status_t;

endpackage

/* rtl/bit_sync.sv */
/*
 * Two-stage synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level; multi-bit groups are not coherent.
 */
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [1:0][WIDTH-1:0] stage;
	logic [1:0][WIDTH-1:0] next_stage;

	// First stage feeds only the second
	always_comb begin
		next_stage[0] = d_i;
		next_stage[1] = stage[0];
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage <= '0;
		end else begin
			stage <= next_stage;
		end
	end

	assign q_o = stage[1];

endmodule

`default_nettype wire

/* rtl/flag_latch.sv */
/*
 * Sticky interrupt source flags, one per source, set by event pulses
 * and cleared per bit by a clear vector.
 * Assumes set and clear arrive on the same clock as this block.
 */
`timescale 1ns/10ps
`default_nettype none

module flag_latch
	import phy_irq_pkg::*;
(
	input  wire logic      clock_i,
	input  wire logic      rst_n_i,
	input  wire flag_vec_t set_i,
	input  wire flag_vec_t clear_i,
	output flag_vec_t      flags_o
);

	typedef struct packed {
		flag_vec_t flags;
	} latch_state_t;

	latch_state_t state;
	latch_state_t next_state;
	flag_vec_t    next_flags;
	flag_vec_t    keep;

	// Set beats clear so an event in the clearing cycle survives
	for (genvar i = FLAG_LO; i <= FLAG_HI; i++) begin : g_flag
		assign keep[i]       = state.flags[i] & ~clear_i[i];
		assign next_flags[i] = set_i[i] | keep[i];
	end

	always_comb begin
		next_state.flags = next_flags;
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state.flags <= FLAGS_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign flags_o = state.flags;

	// Every event lands, and nothing falls without its clear
	a_set_lands: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R4]
		(|set_i) |=> ((flags_o & $past(set_i)) == $past(set_i)))
		else $error("flag missed its set event");
	a_flag_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see [R5]
		(|keep) |=> ((flags_o & $past(keep)) == $past(keep)))
		else $error("flag dropped without a clear");

endmodule

`default_nettype wire

/* tb/smi_manager.sv */
/*
 * Management station model: drives whole MDC/MDIO frames on request.
 * Assumes a pull-up on MDIO and a core clock ten times MDC or faster.
 */
`timescale 1ns/10ps
`default_nettype none

module smi_manager
	import phy_irq_pkg::*;
(
	input  wire logic   clock_i,
	input  wire logic   mdio_i,
	output logic        mdc_o,
	output logic        mdio_o,
	output logic        mdio_oe_o,
	output logic [15:0] rd_data_o,
	output logic        rd_valid_o
);
	// MDC stands low between frames
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
		rd_data_o = 16'h0000;
		rd_valid_o = 1'b0;
	end

	// One MDC period; the slave's bit is taken just before the rise
	task automatic bit_slot(input logic oe, input logic b, output logic s);
		mdio_oe_o = oe;
		mdio_o = b;
		repeat (5) @(negedge clock_i);
		s = mdio_i;
		mdc_o = 1'b1;
		repeat (5) @(negedge clock_i);
		mdc_o = 1'b0;
	endtask

	// Whole frame; a read releases the line from turnaround on
	task automatic frame(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd);
		logic [63:0] f;
		logic        rd;
		logic        s;
		rd = (op == OP_READ);
		f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
		for (int i = 63; i >= 0; i--) begin
			bit_slot(!(rd && i < 18), f[i], s);
			if (i < 16)
				rd_data_o[i] = s;
		end
		mdio_oe_o = 1'b0;
		if (rd) begin
			rd_valid_o = 1'b1;
			@(negedge clock_i);
			rd_valid_o = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* tb/phy_irq_status_regs_tb.sv */
/*
 * Self-checking bench for the status and interrupt registers.
 * Assumes the manager model and a pull-up on the management data line.
 */
`timescale 1ns/10ps
`default_nettype none

module phy_irq_status_regs_tb;
	import phy_irq_pkg::*;
	localparam logic [4:0] PA = 5'h0b;
	logic        clock_i, rst_n_i, mdc, m_do, m_oe, d_do, d_oe, rd_valid, irq;
	logic [6:0]  idx_o, idx;
	logic [15:0] rd_data;
	logic [15:0] exp_q[$];
	logic [2:0]  codes[4] = '{SPEED_10_HALF, SPEED_10_FULL, SPEED_100_HALF, SPEED_100_FULL};
	int          pos[11:1] = '{8, 14, 13, 12, 6, 4, 11, 5, 10, 9, 7};
	int          errors, n_tests, b;
	int          seed = 32'h087f33e2;
	phy_status_t st;
	wire         mdio = d_oe ? d_do : (m_oe ? m_do : 1'b1);

	phy_irq_status_regs dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc),
		.mdio_i(mdio), .mdio_o(d_do), .mdio_oe_o(d_oe), .phy_addr_i(PA),
		.status_i(st), .adv_index_o(idx_o), .adv_data_i({idx_o, 2'b01, idx_o}),
		.irq_o(irq));
	smi_manager mgr_u (.clock_i(clock_i), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(m_do),
		.mdio_oe_o(m_oe), .rd_data_o(rd_data), .rd_valid_o(rd_valid));

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One read frame to one register, its expected word queued first
	task automatic rd(input logic [4:0] ra, input logic [15:0] e);
		exp_q.push_back(e);
		mgr_u.frame(OP_READ, PA, ra, 16'h0000);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		mgr_u.frame(OP_WRITE, PA, ra, d);
	endtask
	task automatic wait_irq(input logic e);
		for (int n = 0; n < 40 && irq !== e; n++)
			@(negedge clock_i);
		check({15'h0000, irq}, {15'h0000, e});
	endtask

	// Read results come back in request order
	always @(posedge clock_i) begin
		if (rd_valid)
			check(rd_data, exp_q.pop_front());
	end

	initial begin
		repeat (100000) @(posedge clock_i);
		errors++;
		results();
	end

	initial begin
		rst_n_i = 1'b0;
		st = '0;
		st.link_up = 1'b1;
		repeat (16) @(negedge clock_i);
		rst_n_i = 1'b1;
		rd(REG_ADV_DATA, 16'h0000);
		rd(REG_FLAGS, 16'h0000);
		mgr_u.frame(OP_WRITE, PA ^ 5'h01, REG_MASK, 16'hffff);
		rd(REG_MASK, 16'h0000);
		wr(REG_MASK, 16'hffff);
		rd(REG_MASK, 16'h07fe);
		wr(REG_MASK, 16'h0000);
		$display("reset and mask test done");
		// Index latched only when the read bit is set
		idx = 7'($unsigned($random(seed)) % 13);
		wr(REG_ADV_ADDR, {1'b1, 8'h03, idx});
		rd(REG_ADV_DATA, {idx, 2'b01, idx});
		wr(REG_ADV_ADDR, {1'b0, 8'h03, idx ^ 7'h01});
		rd(REG_ADV_DATA, {idx, 2'b01, idx});
		$display("advanced window test done");
		for (int c = 0; c < 4; c++) begin
			st.resolved_speed_duplex = codes[c];
			st.ten_meg_polarity_reversed = c[0];
			st.autoneg_done = c[1];
			rd(REG_INDICATIONS, {11'h000, c[0], 4'h0});
			rd(REG_SPECIAL, {3'h0, c[1], 7'h00, codes[c], 2'h0});
		end
		rd(REG_FLAGS, 16'h0040);
		st.autoneg_done = 1'b0;
		wr(REG_FLAGS, 16'hffff);
		$display("status test done");
		// Each source, including the second cause of flag 2
		for (int k = 1; k <= 11; k++) begin
			b = (k == 11) ? 2 : k;
			st[pos[k]] = ~st[pos[k]];
			repeat (4) @(negedge clock_i);
			st[pos[k]] = ~st[pos[k]];
			wait_irq(1'b0);
			rd(REG_FLAGS, 16'(1 << b));
			wr(REG_MASK, 16'(1 << b));
			wait_irq(1'b1);
			wr(REG_FLAGS, 16'(1 << b));
			wait_irq(1'b0);
		end
		$display("flag test done");
		repeat (4) @(negedge clock_i);
		results();
	end
endmodule
`default_nettype wire
